/* File: core/ifv_flag_bit.v */
// Purpose: one sticky flag, set by hardware, cleared by software
// Assumes: set and clear are same-clock pulses
// Notes: set wins over clear so no event is lost
`include "ifv_regs.vh"
module ifv_flag_bit (
   clk,
   reset_n,
   clk_en,
   set_evt,
   sw_we,
   sw_val,
   flag
);
   input wire clk;
   input wire reset_n;
   input wire clk_en;
   input wire set_evt;
   input wire sw_we;
   input wire sw_val;
   output reg flag;
   // Event sets regardless of the interrupt enables, but only while clk_en is high
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         flag <= 1'b0;
      else if (clk_en) begin
         if (set_evt)
            flag <= 1'b1;
         else if (sw_we)
            flag <= sw_val;
      end
   end
endmodule // ifv_flag_bit

/* File: core/ifv_irq_ctrl.v */
// Purpose: interrupt flags, enables and vector request for the core
// Assumes: one clk edge per instruction cycle; core drives accept pulse
// Notes: registers are loose ports; writes carry whole bytes
`include "ifv_regs.vh"
module ifv_irq_ctrl (
   clk,
   reset_n,
   clk_en,
   ext_edge_irq_pin,
   portb_upper_nibble,
   edge_polarity_select,
   timer_zero,
   timer_one_ovf,
   timer_two_match,
   capcmp_unit_a_evt,
   capcmp_unit_b_evt,
   rx_evt,
   tx_evt,
   ssp_evt,
   psp_evt,
   ctrl_we,
   ctrl_wdata,
   pera_we,
   pera_wdata,
   perb_we,
   perb_wdata,
   piea_we,
   piea_wdata,
   pieb_we,
   pieb_wdata,
   return_from_isr_instr,
   irq_accept,
   sleeping,
   irq_control_reg,
   periph_flag_reg_a,
   periph_flag_reg_b,
   periph_enable_reg_a,
   periph_enable_reg_b,
   vector_req,
   vector_addr,
   push_return,
   wake_req
);
   input wire clk;
   input wire reset_n;
   input wire clk_en;
   input wire ext_edge_irq_pin;
   input wire [3:0] portb_upper_nibble;
   input wire edge_polarity_select;
   input wire [7:0] timer_zero;
   input wire timer_one_ovf;
   input wire timer_two_match;
   input wire capcmp_unit_a_evt;
   input wire capcmp_unit_b_evt;
   input wire rx_evt;
   input wire tx_evt;
   input wire ssp_evt;
   input wire psp_evt;
   input wire ctrl_we;
   input wire [7:0] ctrl_wdata;
   input wire pera_we;
   input wire [7:0] pera_wdata;
   input wire perb_we;
   input wire [7:0] perb_wdata;
   input wire piea_we;
   input wire [7:0] piea_wdata;
   input wire pieb_we;
   input wire [7:0] pieb_wdata;
   input wire return_from_isr_instr;
   input wire irq_accept;
   input wire sleeping;
   output reg [7:0] irq_control_reg;
   output reg [7:0] periph_flag_reg_a;
   output reg [7:0] periph_flag_reg_b;
   output reg [7:0] periph_enable_reg_a;
   output reg [7:0] periph_enable_reg_b;
   output reg vector_req;
   output reg [12:0] vector_addr;
   output reg push_return;
   output reg wake_req;

   wire ext_lvl;
   wire [3:0] nib_lvl;
   reg ext_prev;
   reg [3:0] nib_prev;
   reg [7:0] t0_prev;
   reg global_irq_enable;
   reg [2:0] ctrl_en;
   reg [1:0] lat_cnt;
   reg lat_run;
   reg wake_pend;
   reg periph_en;
   wire [2:0] core_flag;
   wire [7:0] pera_flag;
   wire [7:0] perb_flag;
   wire ext_edge;
   wire nib_change;
   wire t0_roll;
   wire any_pend;
   wire any_wake;
   wire [2:0] core_set;
   wire [15:0] per_set;
   wire [15:0] per_wval;
   wire [15:0] per_we;
   wire [15:0] per_flag;

   // Pin inputs pass the three-stage filter
   // Costs four edges of latency, traded for glitch immunity
   ifv_pin_sync u_ext_sync (
      .clk(clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .pin(ext_edge_irq_pin),
      .level(ext_lvl)
   );
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_nib
         ifv_pin_sync u_nib_sync (
            .clk(clk),
            .reset_n(reset_n),
            .clk_en(clk_en),
            .pin(portb_upper_nibble[gi]),
            .level(nib_lvl[gi])
         );
      end
   endgenerate

   // Edge and change detection on filtered levels; rollover detection on raw timer_zero
   // Reset levels match the idle-low pins, so no false edge
   assign ext_edge = edge_polarity_select ? (ext_lvl & ~ext_prev)
                                          : (~ext_lvl & ext_prev);
   assign nib_change = |(nib_lvl ^ nib_prev);
   assign t0_roll = (t0_prev == `IFV_T0_MAX) &&
                    (timer_zero == `IFV_T0_ZERO);
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ext_prev <= 1'b0;
         nib_prev <= 4'h0;
         t0_prev <= 8'h00;
      end else if (clk_en) begin
         ext_prev <= ext_lvl;
         nib_prev <= nib_lvl;
         t0_prev <= timer_zero;
      end
   end

   // Core flags live in the control register
   assign core_set = {t0_roll, ext_edge, nib_change};
   // Peripheral set vector, eight sources in total
   // Unused positions are tied zero, so only a software write can set them
   assign per_set = {psp_evt, 1'b0, rx_evt, tx_evt, ssp_evt,
                     capcmp_unit_a_evt, timer_two_match, timer_one_ovf,
                     7'h00, capcmp_unit_b_evt};
   assign per_we = {{8{pera_we}}, {8{perb_we}}};
   assign per_wval = {pera_wdata, perb_wdata};
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_core
         ifv_flag_bit u_flag (
            .clk(clk),
            .reset_n(reset_n),
            .clk_en(clk_en),
            .set_evt(core_set[gi]),
            .sw_we(ctrl_we),
            .sw_val(ctrl_wdata[gi]),
            .flag(core_flag[gi])
         );
      end
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_per
         ifv_flag_bit u_flag (
            .clk(clk),
            .reset_n(reset_n),
            .clk_en(clk_en),
            .set_evt(per_set[gi]),
            .sw_we(per_we[gi]),
            .sw_val(per_wval[gi]),
            .flag(per_flag[gi])
         );
      end
   endgenerate
   assign pera_flag = per_flag[15:8];
   assign perb_flag = per_flag[7:0];

   // Pending: unmasked core or peripheral flag
   // Live enable flop, not the image, so the gate has no lag
   assign any_pend =
      (core_flag[0] & ctrl_en[0]) |
      (core_flag[1] & ctrl_en[1]) |
      (core_flag[2] & ctrl_en[2]) |
      (periph_en &
       |((pera_flag & periph_enable_reg_a) |
         (perb_flag & periph_enable_reg_b)));
   assign any_wake = any_pend;

   // Global enable and individual enables
   // Accept beats return beats write; a clear racing an accept
   // is undone by the later return, so software re-tests it
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         global_irq_enable <= 1'b0;
         ctrl_en <= 3'h0;
         periph_enable_reg_a <= `IFV_PERA_RESET;
         periph_enable_reg_b <= `IFV_PERB_RESET;
      end else if (clk_en) begin
         if (irq_accept)
            global_irq_enable <= 1'b0;
         else if (return_from_isr_instr)
            global_irq_enable <= 1'b1;
         else if (ctrl_we)
            global_irq_enable <= ctrl_wdata[`IFV_BIT_GIE];
         if (ctrl_we)
            ctrl_en <= {ctrl_wdata[`IFV_BIT_T0_EN],
                        ctrl_wdata[`IFV_BIT_EXT_EN],
                        ctrl_wdata[`IFV_BIT_PORTB_EN]};
         if (piea_we)
            periph_enable_reg_a <= piea_wdata;
         if (pieb_we)
            periph_enable_reg_b <= pieb_wdata;
      end
   end

   // Periph enable bit kept in the control register image
   // Written with the control byte, read back in bit 6
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         periph_en <= 1'b0;
      else if (clk_en && ctrl_we)
         periph_en <= ctrl_wdata[`IFV_BIT_PERIPH_EN];
   end

   // Latency: request follows a set flag by two edges and the
   // core adds one, giving three cycles from the flag
   // Limitation: the pin filter adds four edges ahead of this
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lat_run <= 1'b0;
         lat_cnt <= `IFV_LAT_IDLE;
      end else if (clk_en) begin
         if (!(any_pend && global_irq_enable) || irq_accept) begin
            lat_run <= 1'b0;
            lat_cnt <= `IFV_LAT_IDLE;
         end else if (!lat_run) begin
            lat_run <= 1'b1;
            lat_cnt <= `IFV_LAT_START;
         end else if (lat_cnt != `IFV_LAT_MIN)
            lat_cnt <= lat_cnt + 2'h1;
      end
   end

   // Wake from sleep: one more instruction runs first
   // Pending stays high for the first cycle after sleep ends
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         wake_pend <= 1'b0;
      else if (clk_en) begin
         if (sleeping && any_wake)
            wake_pend <= 1'b1;
         else if (!sleeping)
            wake_pend <= 1'b0;
      end
   end

   // Registered outputs toward the core
   // Images lag the flops by one edge; software sees that delay
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_control_reg <= `IFV_CTRL_RESET;
         periph_flag_reg_a <= `IFV_PERA_RESET;
         periph_flag_reg_b <= `IFV_PERB_RESET;
         vector_req <= 1'b0;
         vector_addr <= `IFV_VECTOR;
         push_return <= 1'b0;
         wake_req <= 1'b0;
      end else if (clk_en) begin
         irq_control_reg <= {global_irq_enable, periph_en, ctrl_en, core_flag};
         periph_flag_reg_a <= pera_flag;
         periph_flag_reg_b <= perb_flag;
         // Held off while asleep and for the instruction after wake
         vector_req <= global_irq_enable & any_pend & ~irq_accept & ~sleeping &
                       ~wake_pend & lat_run &
                       (lat_cnt >= `IFV_LAT_START);
         vector_addr <= `IFV_VECTOR;
         push_return <= irq_accept;
         wake_req <= sleeping & any_wake;
      end
   end
endmodule // ifv_irq_ctrl

/* File: core/ifv_pin_sync.v */
// Purpose: three-stage synchroniser with agreement filter for pins
// Assumes: pin is asynchronous to clk
// Notes: stage one feeds only stage two
`include "ifv_regs.vh"
module ifv_pin_sync (
   clk,
   reset_n,
   clk_en,
   pin,
   level
);
   input wire clk;
   input wire reset_n;
   input wire clk_en;
   input wire pin;
   output reg level;
   reg [2:0] stage;
   // Level moves only when stages two and three agree
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stage <= `IFV_SYNC_RESET;
         level <= 1'b0;
      end else if (clk_en) begin
         stage <= {stage[1:0], pin};
         if (stage[1] == stage[2])
            level <= stage[2];
      end
   end
endmodule // ifv_pin_sync

/* File: core/ifv_regs.vh */
// Purpose: constants for the interrupt flag and vector logic
// Assumes: included once per design file
// Notes: bit positions follow the control and peripheral registers
`ifndef IFV_REGS_VH
`define IFV_REGS_VH
`define IFV_CTRL_RESET 8'h00
`define IFV_PERA_RESET 8'h00
`define IFV_PERB_RESET 8'h00
`define IFV_BIT_PORTB_FLAG 0
`define IFV_BIT_EXT_FLAG 1
`define IFV_BIT_T0_FLAG 2
`define IFV_BIT_PORTB_EN 3
`define IFV_BIT_EXT_EN 4
`define IFV_BIT_T0_EN 5
`define IFV_BIT_PERIPH_EN 6
`define IFV_BIT_GIE 7
`define IFV_VECTOR 13'h0004
`define IFV_LAT_MIN 2'h3
`define IFV_LAT_IDLE 2'h0
`define IFV_LAT_START 2'h1
`define IFV_SYNC_RESET 3'h0
`define IFV_T0_MAX 8'hFF
`define IFV_T0_ZERO 8'h00
`endif

/* File: verification/ifv_core_model.sv */
// Purpose: core sequencer answering vector requests
// Assumes: slow asks for a three-cycle answer
// Notes: one accept pulse per request
module ifv_core_model (
   input logic clk,
   input logic reset_n,
   input logic vector_req,
   input logic slow,
   output logic irq_accept
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] wait_cnt;
   // Dropped request restarts the wait, so no stale accept
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_accept <= 1'b0;
         wait_cnt <= 2'h0;
      end else if (irq_accept || !vector_req) begin
         irq_accept <= 1'b0;
         wait_cnt <= 2'h0;
      end else if (wait_cnt == {slow, 1'b0}) begin
         irq_accept <= 1'b1;
      end else begin
         wait_cnt <= wait_cnt + 2'h1;
      end
   end
endmodule // ifv_core_model

/* File: verification/ifv_irq_ctrl_sva.sv */
// Purpose: timing checks on the interrupt controller ports
// Assumes: clk_en held high; images lag flops by one edge
// Notes: bound to every ifv_irq_ctrl instance
module ifv_irq_ctrl_sva (
   input logic clk,
   input logic reset_n,
   input logic clk_en,
   input logic return_from_isr_instr,
   input logic irq_accept,
   input logic sleeping,
   input logic [7:0] irq_control_reg,
   input logic [7:0] periph_flag_reg_a,
   input logic [7:0] periph_flag_reg_b,
   input logic vector_req,
   input logic [12:0] vector_addr,
   input logic push_return,
   input logic wake_req
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Core accept, and the pin request seen as enabled and pending
   sequence s_acc;
      clk_en && irq_accept;
   endsequence
   sequence s_pend;
      irq_control_reg[7] && irq_control_reg[4] && irq_control_reg[1]
         && !sleeping && !irq_accept;
   endsequence
   vec_addr_a: assert property (vector_addr == 13'h0004)
      else $error("vector address moved");
   acc_push_a: assert property (s_acc |=> push_return && !vector_req)
      else $error("accept not followed by push");
   acc_clear_a: assert property (s_acc |-> ##2 !irq_control_reg[7])
      else $error("enable kept after accept");
   ret_set_a: assert property (clk_en && return_from_isr_instr
      && !irq_accept |-> ##2 irq_control_reg[7])
      else $error("return left enable clear");
   reset_off_a: assert property ($rose(reset_n) |-> !irq_control_reg[7])
      else $error("enable set out of reset");
   req_gate_a: assert property ($rose(vector_req) |->
      $past(irq_control_reg[7]))
      else $error("request while disabled");
   pend_req_a: assert property (s_pend [*4] |-> vector_req)
      else $error("pending source not requested");
   sleep_hold_a: assert property (sleeping && $past(sleeping)
      |-> !vector_req)
      else $error("request during sleep");
   wake_flag_a: assert property ($rose(wake_req) |-> ##[0:2]
      (|{irq_control_reg[2:0], periph_flag_reg_a, periph_flag_reg_b}))
      else $error("wake without flag");
endmodule // ifv_irq_ctrl_sva
bind ifv_irq_ctrl ifv_irq_ctrl_sva i_ifv_irq_ctrl_sva (.clk, .reset_n,
   .clk_en, .return_from_isr_instr, .irq_accept, .sleeping,
   .irq_control_reg, .periph_flag_reg_a, .periph_flag_reg_b, .vector_req,
   .vector_addr, .push_return, .wake_req);

/* File: verification/tb.sv */
// Purpose: directed bench for interrupt flag and vector logic
// Assumes: core model accepts requests
// Notes: images settle two edges after a write
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic ext_edge_irq_pin = 1'b0;
   logic edge_polarity_select = 1'b1;
   logic sleeping = 1'b0;
   logic return_from_isr_instr = 1'b0;
   logic slow = 1'b0;
   logic [3:0] portb_upper_nibble = 4'h0;
   logic [7:0] timer_zero = 8'h00;
   logic [7:0] evt = 8'h00;
   logic [4:0] we = 5'h00;
   logic [7:0] wd = 8'h00;
   logic [7:0] m;
   logic [7:0] irq_control_reg, periph_flag_reg_a, periph_flag_reg_b;
   logic [7:0] periph_enable_reg_a, periph_enable_reg_b;
   logic irq_accept, vector_req, push_return, wake_req;
   logic [12:0] vector_addr;
   int fail_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   int n;
   always #50 clk = ~clk;
   ifv_irq_ctrl i_ifv_irq_ctrl (.clk, .reset_n, .clk_en(1'b1),
      .ext_edge_irq_pin, .portb_upper_nibble, .edge_polarity_select,
      .timer_zero, .timer_one_ovf(evt[0]), .timer_two_match(evt[1]),
      .capcmp_unit_a_evt(evt[2]), .ssp_evt(evt[3]), .tx_evt(evt[4]),
      .rx_evt(evt[5]), .capcmp_unit_b_evt(evt[6]), .psp_evt(evt[7]),
      .ctrl_we(we[0]), .pera_we(we[1]), .perb_we(we[2]), .piea_we(we[3]),
      .pieb_we(we[4]), .ctrl_wdata(wd), .pera_wdata(wd), .perb_wdata(wd),
      .piea_wdata(wd), .pieb_wdata(wd), .return_from_isr_instr, .irq_accept,
      .sleeping, .irq_control_reg, .periph_flag_reg_a, .periph_flag_reg_b,
      .periph_enable_reg_a, .periph_enable_reg_b, .vector_req, .vector_addr,
      .push_return, .wake_req);
   ifv_core_model i_ifv_core_model (.clk, .reset_n, .vector_req, .slow,
      .irq_accept);
   task automatic chk(input string what, input logic [12:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results;
      $display("compared %0d mismatched %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Sel 0..4 writes a register, 5 pulses events, 6 returns
   task automatic drive(input int sel, input logic [7:0] d);
      @(posedge clk);
      we <= (sel < 5) ? 5'h01 << sel : 5'h00;
      wd <= d;
      evt <= (sel == 5) ? d : 8'h00;
      return_from_isr_instr <= (sel == 6);
      @(posedge clk);
      we <= 5'h00;
      evt <= 8'h00;
      return_from_isr_instr <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   // Bounded wait, so a missing request cannot hang the run
   task automatic wait_req(input int lim);
      n = 0;
      while (vector_req !== 1'b1 && n < lim) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask
   // Cycle ceiling well above the expected few hundred
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         results();
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      #1;
      chk("ctrl", irq_control_reg, 8'h00);
      chk("vector", vector_addr, 13'h0004);
      // Each peripheral source alone, every enable off
      for (int i = 0; i < 8; i++) begin
         m = 8'h01 << i;
         drive(5, m);
         chk("flags a", periph_flag_reg_a, {m[7], 1'b0, m[5:0]});
         chk("flags b", periph_flag_reg_b, {7'h00, m[6]});
         chk("request", vector_req, 1'b0);
         drive(1, 8'h00);
         drive(2, 8'h00);
      end
      // Rising pin ignored on falling select; nibble and rollover
      @(posedge clk);
      edge_polarity_select <= 1'b0;
      ext_edge_irq_pin <= 1'b1;
      portb_upper_nibble <= 4'h5;
      timer_zero <= 8'hFF;
      @(posedge clk);
      timer_zero <= 8'h00;
      repeat (8) @(posedge clk);
      #1;
      chk("ctrl", irq_control_reg, 8'h05);
      drive(0, 8'h00);
      @(posedge clk);
      ext_edge_irq_pin <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      chk("ctrl", irq_control_reg, 8'h02);
      @(posedge clk);
      edge_polarity_select <= 1'b1;
      slow <= 1'b1;
      repeat (6) @(posedge clk);
      // Pin request with a slow core, then service and return
      drive(0, 8'h90);
      @(posedge clk);
      ext_edge_irq_pin <= 1'b1;
      wait_req(12);
      // Four filter edges, then flag edge and two-edge hold
      chk("latency", n, 7);
      repeat (6) @(posedge clk);
      #1;
      chk("ctrl", irq_control_reg, 8'h12);
      drive(0, 8'h10);
      drive(6, 8'h00);
      chk("ctrl", irq_control_reg, 8'h90);
      chk("request", vector_req, 1'b0);
      // Peripheral source waits for the group enable
      slow <= 1'b0;
      drive(3, 8'h01);
      chk("enable a", periph_enable_reg_a, 8'h01);
      drive(4, 8'h01);
      chk("enable b", periph_enable_reg_b, 8'h01);
      drive(5, 8'h01);
      chk("request", vector_req, 1'b0);
      drive(0, 8'hC0);
      wait_req(8);
      chk("request", vector_req, 1'b1);
      repeat (4) @(posedge clk);
      #1;
      chk("ctrl", irq_control_reg, 8'h40);
      drive(1, 8'h00);
      // Wake from sleep: flag and wake first, vector after
      @(posedge clk);
      sleeping <= 1'b1;
      drive(6, 8'h00);
      drive(5, 8'h01);
      chk("wake", wake_req, 1'b1);
      chk("request", vector_req, 1'b0);
      @(posedge clk);
      sleeping <= 1'b0;
      @(posedge clk);
      #1;
      chk("request", vector_req, 1'b0);
      wait_req(8);
      chk("request", vector_req, 1'b1);
      repeat (4) @(posedge clk);
      // Serviced flag cleared, return, then clear until read clear
      drive(1, 8'h00);
      drive(6, 8'h00);
      n = 0;
      while (irq_control_reg[7] !== 1'b0 && n < 4) begin
         drive(0, 8'h40);
         n++;
      end
      chk("ctrl", irq_control_reg, 8'h40);
      results();
   end
endmodule // tb
